//--- wew_axi_host.sv
// processor model: AXI4-Lite master driving the watchdog register block
// assumes tasks are called from one process, one access at a time
`timescale 1ns/10ps
module wew_axi_host (
  input wire logic clk_sys_i,
  output logic [7:0] s_axi_awaddr_o,
  output logic s_axi_awvalid_o,
  input wire logic s_axi_awready_i,
  output logic [31:0] s_axi_wdata_o,
  output logic [3:0] s_axi_wstrb_o,
  output logic s_axi_wvalid_o,
  input wire logic s_axi_wready_i,
  input wire logic [1:0] s_axi_bresp_i,
  input wire logic s_axi_bvalid_i,
  output logic s_axi_bready_o,
  output logic [7:0] s_axi_araddr_o,
  output logic s_axi_arvalid_o,
  input wire logic s_axi_arready_i,
  input wire logic [31:0] s_axi_rdata_i,
  input wire logic [1:0] s_axi_rresp_i,
  input wire logic s_axi_rvalid_i,
  output logic s_axi_rready_o
);
  logic tmo = 1'b0;

  initial begin
    {s_axi_awaddr_o, s_axi_awvalid_o, s_axi_wdata_o, s_axi_wstrb_o, s_axi_wvalid_o} = '0;
    {s_axi_bready_o, s_axi_araddr_o, s_axi_arvalid_o, s_axi_rready_o} = '0;
  end

  // ----------------------------------------------------------------
  // write: address and data offered together, held until each is taken
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp, output int n);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    {aw_ok, w_ok, b_ok} = 3'h0;
    n = 0;
    resp = 2'h3;
    @(posedge clk_sys_i);
    s_axi_awaddr_o <= a;
    s_axi_awvalid_o <= 1'b1;
    s_axi_wdata_o <= {24'h000000, d};
    s_axi_wstrb_o <= 4'hF;
    s_axi_wvalid_o <= 1'b1;
    s_axi_bready_o <= 1'b1;
    while (!b_ok && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
      if (aw_ok && w_ok && s_axi_bvalid_i) begin
        b_ok = 1'b1;
        resp = s_axi_bresp_i;
        s_axi_bready_o <= 1'b0;
      end
      if (!aw_ok && s_axi_awready_i) begin
        aw_ok = 1'b1;
        s_axi_awvalid_o <= 1'b0;
      end
      if (!w_ok && s_axi_wready_i) begin
        w_ok = 1'b1;
        s_axi_wvalid_o <= 1'b0;
      end
    end
    if (!b_ok) tmo = 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_ok;
    logic r_ok;
    int n;
    {ar_ok, r_ok} = 2'h0;
    n = 0;
    d = 32'h00000000;
    resp = 2'h3;
    @(posedge clk_sys_i);
    s_axi_araddr_o <= a;
    s_axi_arvalid_o <= 1'b1;
    s_axi_rready_o <= 1'b1;
    while (!r_ok && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
      if (ar_ok && s_axi_rvalid_i) begin
        r_ok = 1'b1;
        d = s_axi_rdata_i;
        resp = s_axi_rresp_i;
        s_axi_rready_o <= 1'b0;
      end
      if (!ar_ok && s_axi_arready_i) begin
        ar_ok = 1'b1;
        s_axi_arvalid_o <= 1'b0;
      end
    end
    if (!r_ok) tmo = 1'b1;
  endtask
endmodule

//--- wew_pkg.sv
// constants, types and decode helpers for the watchdog early-warning register block
// assumes one system clock; the watchdog count clock arrives as a plain pin
package wew_pkg;

  // ----------------------------------------------------------------
  // bus geometry and answers
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_EARLY_WARNING_OFFSET_CTRL = 6'h02;
  localparam logic [5:0] IDX_IRQ_ENABLE_CLEAR = 6'h04;
  localparam logic [5:0] IDX_IRQ_ENABLE_SET = 6'h05;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h06;
  localparam logic [5:0] IDX_SYNC_STATUS = 6'h07;
  localparam logic [5:0] IDX_SERVICE_KEY = 6'h08;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int EARLY_WARNING_BIT = 0;
  localparam int SYNC_PENDING_BIT = 7;
  localparam logic [3:0] RST_EARLY_WARNING_OFFSET = 4'h0;
  localparam logic RST_IRQ_ENABLE = 1'b0;
  localparam logic RST_IRQ_FLAG = 1'b0;
  localparam logic [7:0] SERVICE_KEY_VALUE = 8'hA5;

  // ----------------------------------------------------------------
  // timing: codes 0 to CODE_MAX select 8 << code watchdog clock cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam logic [14:0] CYCLES_BASE = 15'h0008;
  localparam logic [14:0] CYCLES_CAP = 15'h4000;
  localparam int CLK_PERIOD_NS = 8;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_OFFSET,
    SEL_EN_CLEAR,
    SEL_EN_SET,
    SEL_FLAGS,
    SEL_STATUS,
    SEL_KEY
  } wew_sel_e;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h0,
    WR_STALL = 2'h3,
    WR_RESP = 2'h1
  } wew_wr_state_e;

  typedef struct packed {
    logic enable;
    logic [3:0] period_code;
    logic [3:0] offset_code;
  } wew_timer_cfg_s;

  // reserved codes saturate at the longest count
  function automatic logic [14:0] code_to_cycles(input logic [3:0] code);
    if (code > CODE_MAX) begin
      return CYCLES_CAP;
    end
    return CYCLES_BASE << code;
  endfunction

  function automatic wew_sel_e addr_to_sel(input logic [7:0] addr);
    if (addr[1:0] != 2'h0) begin
      return SEL_NONE;
    end
    case (addr[7:2])
      IDX_EARLY_WARNING_OFFSET_CTRL: return SEL_OFFSET;
      IDX_IRQ_ENABLE_CLEAR: return SEL_EN_CLEAR;
      IDX_IRQ_ENABLE_SET: return SEL_EN_SET;
      IDX_IRQ_FLAGS: return SEL_FLAGS;
      IDX_SYNC_STATUS: return SEL_STATUS;
      IDX_SERVICE_KEY: return SEL_KEY;
      default: return SEL_NONE;
    endcase
  endfunction

endpackage

//--- wew_regs.sv
// register block of the watchdog: early-warning offset, interrupt enable pair,
// flag, sync status and service key, reached over AXI4-Lite
// assumes enable and period code come from neighbouring registers on clk_sys_i
// and that the watchdog count clock is far slower than clk_sys_i
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// RULE1 - early warning fires when count equals offset
// RULE2 - offset loaded from user row at startup
// RULE3 - offset and key writes synced, write-protectable
// RULE4 - reserved bits read zero, software writes zero
// RULE5 - one to enable-clear disables the interrupt
// RULE6 - one to enable-set enables the interrupt
// RULE7 - both enable registers share one bit
// RULE8 - flag set when early-warning point reached
// RULE9 - writing one to flag clears it
// RULE10 - busy bit spans each cross-domain transfer
// RULE11 - key value restarts the time-out period
// RULE12 - any other key value requests reset
// RULE13 - synced write while busy stalls the bus
// RULE14 - period counted by same power-of-two code
// RULE15 - interrupt line is flag and enable
// RULE16 - time-out without key requests system reset
module wew_regs
  import wew_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic watchdog_count_clock_i,
  input wire logic watchdog_enable_i,
  input wire logic [3:0] timeout_period_code_i,
  input wire logic [3:0] nvm_early_warning_offset_i,
  input wire logic write_protect_i,
  output logic early_warning_irq_o,
  output logic system_reset_req_o
);

  // ----------------------------------------------------------------
  // watchdog clock pin to tick
  // ----------------------------------------------------------------
  logic wclk_sync;
  logic wclk_prev_r;
  logic tick;

  wew_sync2 u_wclk_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(watchdog_count_clock_i),
    .q_o(wclk_sync)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wclk_prev_r <= 1'b0;
    end else begin
      wclk_prev_r <= wclk_sync;
    end
  end

  assign tick = wclk_sync && !wclk_prev_r;

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  wew_wr_state_e wr_state_r;
  wew_wr_state_e wr_state_nxt;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic [1:0] bresp_r;
  wew_sel_e wr_sel;
  logic both_held;
  logic wr_is_sync;
  logic wr_stall;
  logic wr_fire;
  logic wr_prot;
  logic wr_do;
  logic sync_pending;

  assign wr_sel = addr_to_sel(awaddr_r);
  assign both_held = aw_held_r && w_held_r;
  assign wr_is_sync = (wr_sel == SEL_OFFSET) || (wr_sel == SEL_KEY);
  assign wr_stall = wr_is_sync && sync_pending; // see RULE13
  assign wr_fire = both_held && (wr_state_r != WR_RESP) && !wr_stall;
  // flags register stays writable under protection
  assign wr_prot = write_protect_i && (wr_sel != SEL_FLAGS) && (wr_sel != SEL_STATUS); // see RULE3
  assign wr_do = wr_fire && !wr_prot && wlane_r && (wr_sel != SEL_NONE) && (wr_sel != SEL_STATUS);

  assign s_axi_awready_o = !aw_held_r;
  assign s_axi_wready_o = !w_held_r;
  assign s_axi_bvalid_o = wr_state_r == WR_RESP;
  assign s_axi_bresp_o = bresp_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata_i[7:0];
      wlane_r <= s_axi_wstrb_i[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_comb begin
    wr_state_nxt = wr_state_r;
    case (wr_state_r)
      WR_COLLECT: begin
        if (both_held) begin
          wr_state_nxt = wr_stall ? WR_STALL : WR_RESP;
        end
      end
      WR_STALL: begin
        if (!wr_stall) begin
          wr_state_nxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready_i) begin
          wr_state_nxt = WR_COLLECT;
        end
      end
      default: wr_state_nxt = WR_COLLECT;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_state_r <= WR_COLLECT;
    end else begin
      wr_state_r <= wr_state_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bresp_r <= (wr_sel == SEL_NONE || wr_prot) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic load_pending_r;
  logic [3:0] ew_offset_r;
  logic [3:0] ew_offset_wd_r;
  logic offset_pend_r;
  logic key_pend_r;
  logic ew_enable_r;
  logic ew_flag_r;
  logic reset_req_r;
  logic ew_event;
  logic timeout;
  logic restart;
  logic bad_key;
  logic key_ok;
  wew_timer_cfg_s timer_cfg;

  assign key_ok = wr_do && (wr_sel == SEL_KEY) && (wdata_r == SERVICE_KEY_VALUE);
  assign bad_key = wr_do && (wr_sel == SEL_KEY) && (wdata_r != SERVICE_KEY_VALUE);
  assign sync_pending = offset_pend_r || key_pend_r;
  assign restart = tick && key_pend_r; // see RULE11

  // strap capture one cycle after reset release, never inside reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      load_pending_r <= 1'b1;
    end else begin
      load_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ew_offset_r <= RST_EARLY_WARNING_OFFSET;
    end else if (load_pending_r) begin
      ew_offset_r <= nvm_early_warning_offset_i; // see RULE2
    end else if (wr_do && wr_sel == SEL_OFFSET) begin
      ew_offset_r <= wdata_r[3:0]; // see RULE4
    end
  end

  // copy seen by the counter, loaded from the strap after reset, then updated only on a watchdog tick
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ew_offset_wd_r <= RST_EARLY_WARNING_OFFSET;
    end else if (load_pending_r) begin
      ew_offset_wd_r <= nvm_early_warning_offset_i;
    end else if (tick && offset_pend_r) begin
      ew_offset_wd_r <= ew_offset_r; // see RULE3
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      offset_pend_r <= 1'b0;
      key_pend_r <= 1'b0;
    end else begin
      offset_pend_r <= (wr_do && wr_sel == SEL_OFFSET) || (offset_pend_r && !tick); // see RULE10
      key_pend_r <= key_ok || (key_pend_r && !tick);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ew_enable_r <= RST_IRQ_ENABLE;
    end else if (wr_do && wr_sel == SEL_EN_SET && wdata_r[EARLY_WARNING_BIT]) begin
      ew_enable_r <= 1'b1; // see RULE6
    end else if (wr_do && wr_sel == SEL_EN_CLEAR && wdata_r[EARLY_WARNING_BIT]) begin
      ew_enable_r <= 1'b0; // see RULE5
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ew_flag_r <= RST_IRQ_FLAG;
    end else if (ew_event) begin
      ew_flag_r <= 1'b1; // see RULE8
    end else if (wr_do && wr_sel == SEL_FLAGS && wdata_r[EARLY_WARNING_BIT]) begin
      ew_flag_r <= 1'b0; // see RULE9
    end
  end

  // held until the system reset this request causes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reset_req_r <= 1'b0;
    end else if (bad_key || timeout) begin
      reset_req_r <= 1'b1; // see RULE12 and RULE16
    end
  end

  assign early_warning_irq_o = ew_flag_r && ew_enable_r; // see RULE15
  assign system_reset_req_o = reset_req_r;
  assign timer_cfg = '{enable: watchdog_enable_i, period_code: timeout_period_code_i, offset_code: ew_offset_wd_r};

  wew_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .restart_i(restart),
    .cfg_i(timer_cfg),
    .early_warning_o(ew_event),
    .timeout_o(timeout)
  );

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  wew_sel_e rd_sel;

  assign rd_sel = addr_to_sel(s_axi_araddr_i);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    case (rd_sel)
      SEL_OFFSET: rd_word[3:0] = ew_offset_r;
      SEL_EN_CLEAR: rd_word[EARLY_WARNING_BIT] = ew_enable_r; // see RULE7
      SEL_EN_SET: rd_word[EARLY_WARNING_BIT] = ew_enable_r; // see RULE7
      SEL_FLAGS: rd_word[EARLY_WARNING_BIT] = ew_flag_r;
      SEL_STATUS: rd_word[SYNC_PENDING_BIT] = sync_pending; // see RULE10
      SEL_KEY: rd_word = 32'h0000_0000;
      default: rd_resp = RESP_SLVERR;
    endcase
  end

  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word; // see RULE4
      rresp_r <= rd_resp;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  nvm_load_seen_a: assert property ($fell(load_pending_r) |-> // see RULE2
    ew_offset_r == $past(nvm_early_warning_offset_i) && ew_offset_wd_r == $past(nvm_early_warning_offset_i))
    else $error("offset not taken from user row");

  protect_blocks_a: assert property (wr_fire && write_protect_i && wr_sel == SEL_OFFSET |=> // see RULE3
    $stable(ew_offset_r) && !offset_pend_r)
    else $error("protected offset write took effect");

  reserved_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000 && // see RULE4
    s_axi_rdata_o[6:4] == 3'h0)
    else $error("reserved read bits not zero");

  enable_clear_a: assert property (wr_do && wr_sel == SEL_EN_CLEAR && wdata_r[0] |=> !ew_enable_r) // see RULE5
    else $error("enable clear ignored");

  enable_set_a: assert property (wr_do && wr_sel == SEL_EN_SET && wdata_r[0] |=> ew_enable_r) // see RULE6
    else $error("enable set ignored");

  flag_set_a: assert property (ew_event |=> ew_flag_r) // see RULE8
    else $error("early warning flag not set");

  flag_clear_a: assert property (wr_do && wr_sel == SEL_FLAGS && wdata_r[0] && !ew_event |=> // see RULE9
    !ew_flag_r)
    else $error("flag clear ignored");

  busy_span_a: assert property ((wr_do && wr_is_sync && !bad_key) || (sync_pending && !tick) |=> sync_pending) // see RULE10
    else $error("busy dropped before transfer done");

  busy_ends_a: assert property (sync_pending && tick && !wr_do |=> !sync_pending) // see RULE10
    else $error("busy not cleared at transfer end");

  key_restart_a: assert property (key_pend_r && tick |=> u_timer.count_r == 15'h0000 && !key_pend_r) // see RULE11
    else $error("key did not restart period");

  bad_key_reset_a: assert property (bad_key |=> system_reset_req_o && !sync_pending) // see RULE12
    else $error("wrong key did not request reset");

  stall_hold_a: assert property (both_held && wr_is_sync && sync_pending && wr_state_r != WR_RESP |=> // see RULE13
    !s_axi_bvalid_o && aw_held_r)
    else $error("synced write not stalled");

  irq_follows_a: assert property ($rose(early_warning_irq_o) |-> ew_enable_r && ew_flag_r && // see RULE15
    ($past(ew_event) || $past(wr_do)))
    else $error("interrupt raised without cause");

  timeout_reset_a: assert property (timeout |=> system_reset_req_o [*2]) // see RULE16
    else $error("timeout did not request reset");

endmodule

//--- wew_regs_tb.sv
// self-checking bench for the watchdog early-warning register block
// assumes the processor model drives the bus; watchdog clock runs free
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module wew_regs_tb
  import wew_pkg::*;
;
  localparam logic [7:0] A_OFF = {IDX_EARLY_WARNING_OFFSET_CTRL, 2'b00};
  localparam logic [7:0] A_ECLR = {IDX_IRQ_ENABLE_CLEAR, 2'b00};
  localparam logic [7:0] A_ESET = {IDX_IRQ_ENABLE_SET, 2'b00};
  localparam logic [7:0] A_FLG = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [7:0] A_STS = {IDX_SYNC_STATUS, 2'b00};
  localparam logic [7:0] A_KEY = {IDX_SERVICE_KEY, 2'b00};
  logic clk_sys_i, rst_i, wd_clk, wd_en, wp, irq, rst_req;
  logic [3:0] per_code, nvm_off;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int error_cnt, check_count, ncyc;

  wew_axi_host u_host (.clk_sys_i(clk_sys_i), .s_axi_awaddr_o(awaddr), .s_axi_awvalid_o(awvalid),
    .s_axi_awready_i(awready), .s_axi_wdata_o(wdata), .s_axi_wstrb_o(wstrb), .s_axi_wvalid_o(wvalid),
    .s_axi_wready_i(wready), .s_axi_bresp_i(bresp), .s_axi_bvalid_i(bvalid), .s_axi_bready_o(bready),
    .s_axi_araddr_o(araddr), .s_axi_arvalid_o(arvalid), .s_axi_arready_i(arready), .s_axi_rdata_i(rdata),
    .s_axi_rresp_i(rresp), .s_axi_rvalid_i(rvalid), .s_axi_rready_o(rready));

  wew_regs u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .watchdog_count_clock_i(wd_clk),
    .watchdog_enable_i(wd_en), .timeout_period_code_i(per_code), .nvm_early_warning_offset_i(nvm_off),
    .write_protect_i(wp), .early_warning_irq_o(irq), .system_reset_req_o(rst_req));

  // ----------------------------------------------------------------
  // clocks; watchdog clock phase deliberately unrelated to the bus clock
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
  end
  initial begin
    wd_clk = 1'b0;
    forever #67 wd_clk = ~wd_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    u_host.wr(a, d, rsp, ncyc);
    if (u_host.tmo) begin error_cnt++; stop_test(); end
    `CHK("bresp", er, rsp)
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    u_host.rd(a, rdv, rsp);
    if (u_host.tmo) begin error_cnt++; stop_test(); end
    `CHK("rdata", ex, rdv)
    `CHK("rresp", er, rsp)
  endtask

  // busy clears only after a watchdog tick, so poll with a bound
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      u_host.rd(A_STS, rdv, rsp);
      k++;
    end while (rdv[SYNC_PENDING_BIT] !== 1'b0 && k < 60);
    if (k >= 60 || u_host.tmo) begin error_cnt++; stop_test(); end
  endtask

  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, wd_en, wp, per_code, nvm_off} = {1'b1, 1'b0, 1'b0, 4'h1, 4'h3};
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    r(A_OFF, 32'h3, RESP_OKAY);
    r(A_ECLR, 32'h0, RESP_OKAY);
    r(A_ESET, 32'h0, RESP_OKAY);
    r(A_FLG, 32'h0, RESP_OKAY);
    r(A_STS, 32'h0, RESP_OKAY);
    $display("test reset values done");
    w(A_ESET, 8'h01, RESP_OKAY);
    r(A_ECLR, 32'h1, RESP_OKAY);
    w(A_ECLR, 8'h00, RESP_OKAY);
    r(A_ESET, 32'h1, RESP_OKAY);
    w(A_ECLR, 8'h01, RESP_OKAY);
    r(A_ESET, 32'h0, RESP_OKAY);
    w(A_ESET, 8'h00, RESP_OKAY);
    r(A_ECLR, 32'h0, RESP_OKAY);
    $display("test enable pair done");
    wp <= 1'b1;
    w(A_ESET, 8'h01, RESP_SLVERR);
    r(A_ESET, 32'h0, RESP_OKAY);
    w(A_OFF, 8'h05, RESP_SLVERR);
    r(A_OFF, 32'h3, RESP_OKAY);
    w(A_KEY, 8'h5A, RESP_SLVERR);
    `CHK("reset_req", 1'b0, rst_req)
    w(A_FLG, 8'h01, RESP_OKAY);
    wp <= 1'b0;
    r(8'h0C, 32'h0, RESP_SLVERR);
    r(8'h09, 32'h0, RESP_SLVERR);
    w(8'h0C, 8'h01, RESP_SLVERR);
    r(A_KEY, 32'h0, RESP_OKAY);
    $display("test protection and map done");
    @(posedge wd_clk);
    repeat (2) @(posedge clk_sys_i);
    w(A_OFF, 8'h00, RESP_OKAY);
    r(A_STS, 32'h80, RESP_OKAY);
    w(A_OFF, 8'h0B, RESP_OKAY);
    `CHK("stalled", 1'b1, ncyc > 4)
    r(A_OFF, 32'hB, RESP_OKAY);
    wait_idle();
    `CHK("sync_done", 32'h0, rdv)
    for (int i = 0; i < 12; i++) begin
      w(A_OFF, 8'(i), RESP_OKAY);
      r(A_OFF, 32'(i), RESP_OKAY);
    end
    w(A_OFF, 8'h00, RESP_OKAY);
    $display("test sync and codes done");
    wd_en <= 1'b1;
    w(A_KEY, SERVICE_KEY_VALUE, RESP_OKAY);
    wait_idle();
    w(A_ESET, 8'h01, RESP_OKAY);
    repeat (5) @(posedge wd_clk);
    r(A_FLG, 32'h0, RESP_OKAY);
    `CHK("irq_quiet", 1'b0, irq)
    repeat (5) @(posedge wd_clk);
    r(A_FLG, 32'h1, RESP_OKAY);
    `CHK("irq_up", 1'b1, irq)
    `CHK("no_timeout", 1'b0, rst_req)
    w(A_FLG, 8'h00, RESP_OKAY);
    r(A_FLG, 32'h1, RESP_OKAY);
    w(A_FLG, 8'h01, RESP_OKAY);
    r(A_FLG, 32'h0, RESP_OKAY);
    `CHK("irq_down", 1'b0, irq)
    w(A_KEY, SERVICE_KEY_VALUE, RESP_OKAY);
    wait_idle();
    repeat (12) @(posedge wd_clk);
    `CHK("serviced", 1'b0, rst_req)
    repeat (8) @(posedge wd_clk);
    `CHK("timeout", 1'b1, rst_req)
    $display("test early warning and timeout done");
    wd_en <= 1'b0;
    nvm_off <= 4'h7;
    do_reset();
    r(A_OFF, 32'h7, RESP_OKAY);
    `CHK("reset_clear", 1'b0, rst_req)
    w(A_KEY, 8'h5A, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    `CHK("bad_key", 1'b1, rst_req)
    $display("test wrong key done");
    stop_test();
  end
endmodule

//--- wew_sync2.sv
// two-flop level synchroniser
// assumes d_i is asynchronous to clk_sys_i
`timescale 1ns/10ps
module wew_sync2 (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

//--- wew_timer.sv
// watchdog time-out counter with early-warning point
// assumes tick_i is a one-cycle pulse per watchdog clock cycle
`timescale 1ns/10ps
module wew_timer
  import wew_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic restart_i,
  input wire wew_timer_cfg_s cfg_i,
  output logic early_warning_o,
  output logic timeout_o
);

  logic [14:0] count_r;
  logic [14:0] count_nxt;
  logic advance;
  logic hit_period;

  assign count_nxt = count_r + 15'h0001;
  assign advance = tick_i && cfg_i.enable && !restart_i;
  assign hit_period = count_nxt == code_to_cycles(cfg_i.period_code); // see RULE14

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_r <= 15'h0000;
    end else if (restart_i || !cfg_i.enable) begin
      count_r <= 15'h0000; // see RULE11
    end else if (advance) begin
      count_r <= hit_period ? 15'h0000 : count_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      early_warning_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      early_warning_o <= advance && (count_nxt == code_to_cycles(cfg_i.offset_code)); // see RULE1
      timeout_o <= advance && hit_period;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  ew_point_hit_a: assert property (early_warning_o && !timeout_o && $past(cfg_i.enable) |-> // see RULE1
    count_r == code_to_cycles($past(cfg_i.offset_code)))
    else $error("early warning away from offset count");

  period_wrap_a: assert property (timeout_o |-> count_r == 15'h0000 && // see RULE14
    $past(count_r) == 15'(code_to_cycles($past(cfg_i.period_code)) - 15'h0001))
    else $error("timeout not at period count");

  restart_zero_a: assert property (restart_i |=> count_r == 15'h0000 && !timeout_o) // see RULE11
    else $error("restart did not clear count");

endmodule
